// ### samp_pkg.sv
// constants and types for the second alert mask and polarity block
// assumes a management-bus engine that hands over word transfers byte by byte
//
// Functional notes
// - word register, code 0xd6, resets to 0x8000
// - command exists only when pin is fitted
// - enabled status bit set asserts alert, unless bit 1 selects general output
// - bit 15 enables pass transistor fault, default 1
// - bit 14 enables output overcurrent fault
// - bit 13 enables input overvoltage fault
// - bit 12 enables input undervoltage fault
// - bit 11 enables communication or logic error
// - bit 10 enables output overcurrent warning
// - bit 9 enables secondary current warning
// - bit 8 enables input overvoltage warning
// - bit 7 enables input undervoltage warning
// - bit 6 enables output overvoltage warning
// - bit 5 enables output undervoltage warning
// - bit 4 enables current limit active flag
// - bit 3 picks alert polarity, default low
// - bit 1 turns pin into general output
// - bit 0 sets general output level
`default_nettype none

package samp_pkg;

	// command code of the second alert configuration word
	localparam logic [7:0]  SAMP_CFG_CODE    = 8'hd6;
	// value after reset: only the pass transistor enable set
	localparam logic [15:0] SAMP_CFG_RESET   = 16'h8000;
	// bit 2 is reserved and always reads zero
	localparam logic [15:0] SAMP_CFG_WMASK   = 16'hfffb;
	// field positions inside the word
	localparam int          SAMP_EN_LSB      = 4;
	localparam int          SAMP_NUM_FLAGS   = 12;
	localparam int          SAMP_POL_BIT     = 3;
	localparam int          SAMP_GPO_SEL_BIT = 1;
	localparam int          SAMP_GPO_LVL_BIT = 0;
	// bytes in one word transfer
	localparam logic [1:0]  SAMP_WORD_BYTES  = 2'd2;
	// returned for reads past the second byte
	localparam logic [7:0]  SAMP_RD_FILL     = 8'hff;

	// status flags, most significant first so they line up with bits 15..4
	typedef struct packed {
		logic pass_transistor_fault_flag;
		logic output_overcurrent_fault_flag;
		logic input_overvoltage_fault_flag;
		logic input_undervoltage_fault_flag;
		logic comm_logic_error_flag;
		logic output_overcurrent_warning_flag;
		logic secondary_current_warning_flag;
		logic input_overvoltage_warning_flag;
		logic input_undervoltage_warning_flag;
		logic output_overvoltage_warning_flag;
		logic output_undervoltage_warning_flag;
		logic current_limit_active_flag;
	} samp_flags_s;

	// link-side transaction states
	typedef enum logic [2:0] {
		SAMP_LS_IDLE   = 3'b001,
		SAMP_LS_ACTIVE = 3'b010,
		SAMP_LS_IGNORE = 3'b100
	} samp_link_state_e;

endpackage

`default_nettype wire

// ### samp_second_alert.sv
// second alert pin logic: configuration word, mask, polarity and general output
// assumes the bus engine runs on i_lnk_clk and the status flags on i_sys_clk
`default_nettype none

module samp_second_alert #(
	parameter bit HAS_PIN = 1'b1 // variant with the second alert pin fitted
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_rstn,
	input  wire samp_pkg::samp_flags_s i_status_flags,
	input  wire logic               i_lnk_clk,
	input  wire logic               i_lnk_start,
	input  wire logic [7:0]         i_lnk_code,
	input  wire logic               i_lnk_wr_en,
	input  wire logic [7:0]         i_lnk_wr_byte,
	input  wire logic               i_lnk_rd_en,
	input  wire logic               i_lnk_stop,
	output logic                    o_lnk_ack,
	output logic [7:0]              o_lnk_rd_byte,
	output logic                    o_lnk_busy,
	output logic                    o_second_alert_pin,
	output logic                    o_alert_asserted,
	output logic [15:0]             o_cfg_word
);
	import samp_pkg::*;

	// elaboration check: pin presence is a single flag
	if (HAS_PIN !== 1'b0 && HAS_PIN !== 1'b1)
	begin : g_bad_param
		$error("HAS_PIN must be 0 or 1");
	end

	// system clock domain signals

	logic [15:0]               cfg_q;          // the configuration word
	logic [SAMP_NUM_FLAGS-1:0] gated;          // flag and enable per bit
	logic                      alert_raw;      // any enabled flag set
	logic                      pin_d;          // next pin level
	logic                      pin_q;          // registered pin level
	logic                      asserted_q;     // registered logical alert
	logic [2:0]                wr_tgl_sync_q;  // write request toggle, two stages plus edge
	logic                      wr_ack_q;       // write acknowledge toggle
	logic [15:0]               pub_q;          // word published to the link side
	logic                      pub_tgl_q;      // publish toggle
	logic [1:0]                pub_ack_sync_q; // publish acknowledge back in sys domain
	logic                      pub_idle;       // last publish acknowledged

	// link clock domain signals

	samp_link_state_e          lstate_q;       // transaction state
	logic [1:0]                wcnt_q;         // data bytes written so far
	logic [1:0]                rcnt_q;         // data bytes read so far
	logic [7:0]                stage_lo_q;     // first byte received
	logic [7:0]                stage_hi_q;     // second byte received
	logic [15:0]               wr_word_q;      // word held for the crossing
	logic                      wr_tgl_q;       // write request toggle
	logic [1:0]                wr_ack_sync_q;  // write acknowledge synchroniser
	logic [2:0]                pub_sync_q;     // publish toggle, two stages plus edge
	logic                      pub_ack_q;      // publish acknowledge toggle
	logic [15:0]               view_q;         // link copy of the word
	logic                      ack_q;          // command accepted
	logic [7:0]                rd_byte_q;      // byte to return
	logic                      code_hit;       // command code is ours


	// write commit: a new toggle edge from the link side loads the held word
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cfg_q <= SAMP_CFG_RESET;
		end
		else if (wr_tgl_sync_q[2] != wr_tgl_sync_q[1])
		begin
			// wr_word_q is stable while the toggle is unanswered
			cfg_q <= wr_word_q & SAMP_CFG_WMASK;
		end
	end

	// write toggle synchroniser; stage 0 feeds only stage 1
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_tgl_sync_q <= 3'b000;
		end
		else
		begin
			wr_tgl_sync_q <= {wr_tgl_sync_q[1:0], wr_tgl_q};
		end
	end

	// acknowledge follows the synchronised request, after the load
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_ack_q <= 1'b0;
		end
		else
		begin
			wr_ack_q <= wr_tgl_sync_q[2];
		end
	end


	// one gate per enable bit; bit i of the flags meets enable bit 4+i
	for (genvar i = 0; i < SAMP_NUM_FLAGS; i++)
	begin : g_gate
		assign gated[i] = i_status_flags[i] & cfg_q[SAMP_EN_LSB + i];
	end

	// no memory here: the flags are latched upstream, so the alert follows
	// the mask and the flags directly and a mask write acts at once
	assign alert_raw = |gated;

	// pin level: general output, or alert with chosen polarity
	always_comb
	begin
		if (!HAS_PIN)
		begin
			pin_d = 1'b0;
		end
		else if (cfg_q[SAMP_GPO_SEL_BIT])
		begin
			pin_d = cfg_q[SAMP_GPO_LVL_BIT];
		end
		else if (cfg_q[SAMP_POL_BIT])
		begin
			pin_d = alert_raw;
		end
		else
		begin
			pin_d = ~alert_raw;
		end
	end

	// pin and alert flops, one cycle after flags or mask change
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pin_q      <= HAS_PIN; // idle level of an active-low alert
			asserted_q <= 1'b0;
		end
		else
		begin
			pin_q      <= pin_d;
			asserted_q <= HAS_PIN & alert_raw & ~cfg_q[SAMP_GPO_SEL_BIT];
		end
	end


	// acknowledge synchroniser for the publish handshake
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pub_ack_sync_q <= 2'b00;
		end
		else
		begin
			pub_ack_sync_q <= {pub_ack_sync_q[0], pub_ack_q};
		end
	end

	assign pub_idle = (pub_ack_sync_q[1] == pub_tgl_q);

	// republish whenever the word differs; pub_q holds until acknowledged
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pub_q     <= SAMP_CFG_RESET;
			pub_tgl_q <= 1'b0;
		end
		else if (pub_idle && (pub_q != cfg_q))
		begin
			pub_q     <= cfg_q;
			pub_tgl_q <= ~pub_tgl_q;
		end
	end


	// the command is answered only on the variant with the pin
	assign code_hit = HAS_PIN && (i_lnk_code == SAMP_CFG_CODE);

	// transaction state: start picks ours or ignore, stop ends
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			lstate_q <= SAMP_LS_IDLE;
		end
		else if (i_lnk_start)
		begin
			lstate_q <= code_hit ? SAMP_LS_ACTIVE : SAMP_LS_IGNORE;
		end
		else if (i_lnk_stop)
		begin
			lstate_q <= SAMP_LS_IDLE;
		end
	end

	// acknowledge stands for the whole transaction when the code is ours
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ack_q <= 1'b0;
		end
		else if (i_lnk_start)
		begin
			ack_q <= code_hit;
		end
		else if (i_lnk_stop)
		begin
			ack_q <= 1'b0;
		end
	end


	// low byte first, high byte second, anything further is dropped
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wcnt_q     <= 2'd0;
			stage_lo_q <= 8'h00;
			stage_hi_q <= 8'h00;
		end
		else if (i_lnk_start)
		begin
			wcnt_q <= 2'd0;
		end
		else if (i_lnk_wr_en && lstate_q == SAMP_LS_ACTIVE)
		begin
			unique case (wcnt_q)
				2'd0:
				begin
					stage_lo_q <= i_lnk_wr_byte;
					wcnt_q     <= 2'd1;
				end
				2'd1:
				begin
					stage_hi_q <= i_lnk_wr_byte;
					wcnt_q     <= 2'd2;
				end
				default:
				begin
					// overlong write: extra bytes saturate the count
					wcnt_q <= 2'd3;
				end
			endcase
		end
	end

	// commit on stop only for exactly two bytes and an idle crossing;
	// a write during a pending commit is dropped, o_lnk_busy warns of it
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_word_q <= SAMP_CFG_RESET;
			wr_tgl_q  <= 1'b0;
		end
		else if (i_lnk_stop && lstate_q == SAMP_LS_ACTIVE &&
			wcnt_q == SAMP_WORD_BYTES && !o_lnk_busy)
		begin
			wr_word_q <= {stage_hi_q, stage_lo_q};
			wr_tgl_q  <= ~wr_tgl_q;
		end
	end

	// write acknowledge synchroniser
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wr_ack_sync_q <= 2'b00;
		end
		else
		begin
			wr_ack_sync_q <= {wr_ack_sync_q[0], wr_ack_q};
		end
	end

	assign o_lnk_busy = (wr_tgl_q != wr_ack_sync_q[1]);


	// publish toggle synchroniser with an edge stage
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pub_sync_q <= 3'b000;
		end
		else
		begin
			pub_sync_q <= {pub_sync_q[1:0], pub_tgl_q};
		end
	end

	// capture the stable published word, then acknowledge it
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			view_q    <= SAMP_CFG_RESET;
			pub_ack_q <= 1'b0;
		end
		else
		begin
			if (pub_sync_q[2] != pub_sync_q[1])
			begin
				view_q <= pub_q;
			end
			pub_ack_q <= pub_sync_q[2];
		end
	end


	// low byte then high byte; a read straight after a write may still
	// show the old word until the publish loop has come round
	always_ff @(posedge i_lnk_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rcnt_q    <= 2'd0;
			rd_byte_q <= 8'h00;
		end
		else if (i_lnk_start)
		begin
			rcnt_q <= 2'd0;
		end
		else if (i_lnk_rd_en && lstate_q == SAMP_LS_ACTIVE)
		begin
			unique case (rcnt_q)
				2'd0:
				begin
					rd_byte_q <= view_q[7:0];
					rcnt_q    <= 2'd1;
				end
				2'd1:
				begin
					rd_byte_q <= view_q[15:8];
					rcnt_q    <= 2'd2;
				end
				default:
				begin
					rd_byte_q <= SAMP_RD_FILL;
				end
			endcase
		end
	end


	assign o_lnk_ack          = ack_q;
	assign o_lnk_rd_byte      = rd_byte_q;
	assign o_second_alert_pin = pin_q;
	assign o_alert_asserted   = asserted_q;
	assign o_cfg_word         = cfg_q;

endmodule

`default_nettype wire

// ### samp_host_model.sv
// link-side host model: issues word writes and reads on the byte handshake
// assumes its tasks are called only after reset has been released
`default_nettype none

module samp_host_model (
	input  wire logic       i_lnk_clk,
	input  wire logic       i_ack,
	input  wire logic [7:0] i_rd_byte,
	output logic            o_start,
	output logic [7:0]      o_code,
	output logic            o_wr_en,
	output logic [7:0]      o_wr_byte,
	output logic            o_rd_en,
	output logic            o_stop
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle strobes low from time zero
	initial
	begin
		o_start = 1'b0;
		o_code = 8'h00;
		o_wr_en = 1'b0;
		o_wr_byte = 8'h00;
		o_rd_en = 1'b0;
		o_stop = 1'b0;
	end

	// start and code, then an optional stall before the data bytes
	task automatic open_frame(input logic [7:0] code, input int gap);
		@(posedge i_lnk_clk);
		o_start <= 1'b1;
		o_code <= code;
		@(posedge i_lnk_clk);
		o_start <= 1'b0;
		o_code <= ~code; // released code shows no stale value
		repeat (gap) @(posedge i_lnk_clk);
	endtask

	// write nb bytes; a count other than two is only for refusal tests
	task automatic wr(input logic [7:0] code, input logic [15:0] w, input int nb, input int gap);
		int i;
		open_frame(code, gap);
		for (i = 0; i < nb; i++)
		begin
			o_wr_en <= 1'b1;
			o_wr_byte <= w[8*(i%2) +: 8];
			@(posedge i_lnk_clk);
		end
		o_wr_en <= 1'b0;
		o_wr_byte <= ~o_wr_byte; // no stale byte after release
		o_stop <= 1'b1;
		@(posedge i_lnk_clk);
		o_stop <= 1'b0;
	endtask

	// three byte reads: low, high, then one past the word
	task automatic rd(input logic [7:0] code, output logic [15:0] w, output logic [7:0] x,
		output logic acked);
		open_frame(code, 0);
		o_rd_en <= 1'b1;
		@(posedge i_lnk_clk);
		acked = i_ack;
		@(posedge i_lnk_clk);
		w[7:0] = i_rd_byte;
		@(posedge i_lnk_clk);
		w[15:8] = i_rd_byte;
		o_rd_en <= 1'b0;
		o_stop <= 1'b1;
		@(posedge i_lnk_clk);
		x = i_rd_byte;
		o_stop <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ### samp_second_alert_sva.sv
// checker for the second alert block; sees only its ports
// assumes one async active-low reset over both clock domains
`default_nettype none

module samp_second_alert_sva
	import samp_pkg::*;
#(
	parameter bit HAS_PIN = 1'b1 // pin fitted
) (
	input wire logic                  i_sys_clk,
	input wire logic                  i_rstn,
	input wire samp_pkg::samp_flags_s i_status_flags,
	input wire logic                  i_lnk_clk,
	input wire logic                  i_lnk_start,
	input wire logic [7:0]            i_lnk_code,
	input wire logic                  o_lnk_ack,
	input wire logic                  o_lnk_busy,
	input wire logic                  o_second_alert_pin,
	input wire logic                  o_alert_asserted,
	input wire logic [15:0]           o_cfg_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// any enabled flag set: the cause of an alert
	logic hit;
	assign hit = |(i_status_flags & o_cfg_word[15:4]);

	// pin levels lag their causes by exactly one system edge
	AST_GPO_LEVEL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		HAS_PIN && $past(i_rstn) && $past(o_cfg_word[1])
		|-> o_second_alert_pin == $past(o_cfg_word[0])) else $error("gpo level wrong");
	AST_ALERT_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		HAS_PIN && $past(i_rstn) && $past(o_cfg_word[3:1]) == 3'b000
		|-> o_second_alert_pin == !$past(hit)) else $error("low alert wrong");
	AST_ALERT_HIGH: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		HAS_PIN && $past(i_rstn) && $past(o_cfg_word[3:1]) == 3'b100
		|-> o_second_alert_pin == $past(hit)) else $error("high alert wrong");
	AST_ASSERTED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		HAS_PIN && $past(i_rstn)
		|-> o_alert_asserted == ($past(hit) && !$past(o_cfg_word[1]))) else $error("asserted wrong");
	// config moves only while a committed write is crossing
	AST_CFG_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$changed(o_cfg_word) |-> $past(o_lnk_busy)) else $error("config changed unasked");
	// link answers: own code acked only where the pin exists
	AST_ACK_RISE: assert property (@(posedge i_lnk_clk) disable iff (!i_rstn)
		i_lnk_start && i_lnk_code == SAMP_CFG_CODE |=> o_lnk_ack == HAS_PIN)
		else $error("ack wrong for own code");
	AST_ACK_OTHER: assert property (@(posedge i_lnk_clk) disable iff (!i_rstn)
		i_lnk_start && i_lnk_code != SAMP_CFG_CODE |=> !o_lnk_ack) else $error("foreign code acked");
	AST_BUSY_BOUND: assert property (@(posedge i_lnk_clk) disable iff (!i_rstn)
		$rose(o_lnk_busy) |-> ##[1:24] !o_lnk_busy) else $error("busy stuck");

	COV_ALERT: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) $rose(o_alert_asserted));
	COV_GPO: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_cfg_word[1] && o_second_alert_pin);
	COV_BUSY: cover property (@(posedge i_lnk_clk) disable iff (!i_rstn) $rose(o_lnk_busy));
endmodule

`default_nettype wire

// ### samp_second_alert_tb.sv
// self-checking bench for the second alert block with a link host model
// assumes package, design, checker and host model are compiled first
`default_nettype none

module samp_second_alert_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import samp_pkg::*;

	logic        sys_clk = 1'b0; // 10 MHz
	logic        lnk_clk = 1'b0; // 64 ns, own phase
	logic        rstn;           // async, active low
	samp_flags_s flags;          // status flags to both variants
	logic        start, wr_en, rd_en, stop, ack, busy, pin, asrt, ack_n, pin_n;
	logic [7:0]  code, wr_byte, rd_byte;
	logic [15:0] cfg;
	logic [15:0] cfg_n;                // word of the pinless variant
	logic        ack_n_seen = 1'b0;    // pinless variant ever acknowledged
	int          errors;
	int          check_count;

	always #50 sys_clk = ~sys_clk;
	// link clock offset so edges never line up with the system clock
	initial
	begin
		#13;
		forever #32 lnk_clk = ~lnk_clk;
	end

	samp_second_alert u_dut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_status_flags(flags),
		.i_lnk_clk(lnk_clk), .i_lnk_start(start), .i_lnk_code(code), .i_lnk_wr_en(wr_en),
		.i_lnk_wr_byte(wr_byte), .i_lnk_rd_en(rd_en), .i_lnk_stop(stop), .o_lnk_ack(ack),
		.o_lnk_rd_byte(rd_byte), .o_lnk_busy(busy), .o_second_alert_pin(pin),
		.o_alert_asserted(asrt), .o_cfg_word(cfg));
	// variant without the pin, fed the same traffic
	samp_second_alert #(.HAS_PIN(1'b0)) u_dut_nopin (.i_sys_clk(sys_clk), .i_rstn(rstn),
		.i_status_flags(flags), .i_lnk_clk(lnk_clk), .i_lnk_start(start), .i_lnk_code(code),
		.i_lnk_wr_en(wr_en), .i_lnk_wr_byte(wr_byte), .i_lnk_rd_en(rd_en), .i_lnk_stop(stop),
		.o_lnk_ack(ack_n), .o_lnk_rd_byte(), .o_lnk_busy(), .o_second_alert_pin(pin_n),
		.o_alert_asserted(), .o_cfg_word(cfg_n));
	samp_host_model u_host (.i_lnk_clk(lnk_clk), .i_ack(ack), .i_rd_byte(rd_byte),
		.o_start(start), .o_code(code), .o_wr_en(wr_en), .o_wr_byte(wr_byte), .o_rd_en(rd_en),
		.o_stop(stop));

	// sticky watch: the pinless variant must never answer, even to its own code
	always @(posedge lnk_clk)
		if (ack_n !== 1'b0)
			ack_n_seen <= 1'b1;

	// one comparison, counted
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// bounded wait for the crossing, then for publish and pin to settle
	task automatic settle();
		int n;
		repeat (2) @(posedge lnk_clk);
		for (n = 0; n < 40 && busy === 1'b1; n++)
			@(posedge lnk_clk);
		chk("busy", 16'h0, {15'h0, busy});
		repeat (6) @(posedge sys_clk);
	endtask

	task automatic wr_cfg(input logic [15:0] w, input int nb, input int gap);
		u_host.wr(SAMP_CFG_CODE, w, nb, gap);
		settle();
	endtask

	// new flags, then three edges for the registered pin
	task automatic fl(input logic [11:0] f);
		@(posedge sys_clk);
		flags <= samp_flags_s'(f);
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic rd_chk(input logic [15:0] exp);
		logic [15:0] w;
		logic [7:0]  x;
		logic        a;
		u_host.rd(SAMP_CFG_CODE, w, x, a);
		chk("ack", 16'h1, {15'h0, a});
		chk("read", exp, w);
		chk("fill", {8'h00, SAMP_RD_FILL}, {8'h00, x});
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, far beyond the few hundred system cycles needed
	initial
	begin
		repeat (30000) @(posedge sys_clk);
		errors++;
		test_done();
	end

	initial
	begin
		int i;
		rstn = 1'b0;
		flags = '0;
		errors = 0;
		check_count = 0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge lnk_clk);
		chk("cfg", 16'h8000, cfg);
		chk("pin", 16'h1, {15'h0, pin});
		rd_chk(16'h8000);
		fl(12'h800);
		chk("pin", 16'h0, {15'h0, pin});
		chk("asserted", 16'h1, {15'h0, asrt});
		chk("pin_n", 16'h0, {15'h0, pin_n});
		fl(12'h7ff);
		chk("pin", 16'h1, {15'h0, pin});
		// each enable alone: its own flag fires, all others are masked
		for (i = 0; i < 12; i++)
		begin
			wr_cfg(16'h0010 << i, 2, i % 3);
			chk("cfg", 16'h0010 << i, cfg);
			fl(12'h001 << i);
			chk("pin", 16'h0, {15'h0, pin});
			fl(~(12'h001 << i));
			chk("pin", 16'h1, {15'h0, pin});
		end
		// polarity flip with no new flag event
		fl(12'h000);
		wr_cfg(16'h8008, 2, 0);
		chk("pin", 16'h0, {15'h0, pin});
		fl(12'h800);
		chk("pin", 16'h1, {15'h0, pin});
		wr_cfg(16'h8002, 2, 0);
		chk("pin", 16'h0, {15'h0, pin});
		chk("asserted", 16'h0, {15'h0, asrt});
		wr_cfg(16'h8003, 2, 1);
		chk("pin", 16'h1, {15'h0, pin});
		wr_cfg(16'hffff, 2, 0);
		chk("cfg", 16'hfffb, cfg);
		wr_cfg(16'h12a5, 2, 2);
		rd_chk(16'h12a1);
		// refused: short and long writes, foreign code
		wr_cfg(16'h0000, 1, 0);
		chk("cfg", 16'h12a1, cfg);
		wr_cfg(16'h0000, 3, 0);
		chk("cfg", 16'h12a1, cfg);
		u_host.wr(8'hd5, 16'h0000, 2, 0);
		settle();
		chk("cfg", 16'h12a1, cfg);
		chk("ack_n", 16'h0, {15'h0, ack_n_seen});
		chk("cfg_n", 16'h8000, cfg_n);
		// reset in mid-run: held two system edges, brings back the power-up word
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge lnk_clk);
		chk("cfg", 16'h8000, cfg);
		chk("pin", 16'h0, {15'h0, pin});
		rd_chk(16'h8000);
		test_done();
	end
endmodule

bind samp_second_alert samp_second_alert_sva #(.HAS_PIN(HAS_PIN)) u_sva (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_status_flags(i_status_flags),
	.i_lnk_clk(i_lnk_clk), .i_lnk_start(i_lnk_start), .i_lnk_code(i_lnk_code),
	.o_lnk_ack(o_lnk_ack), .o_lnk_busy(o_lnk_busy), .o_second_alert_pin(o_second_alert_pin),
	.o_alert_asserted(o_alert_asserted), .o_cfg_word(o_cfg_word));

`default_nettype wire
